// [hdl/acr_regs.svh]
// Register offsets, field positions, reset values and serial frame geometry of the config slice
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// ****************************************************************
// Register offsets on the serial control port
// ****************************************************************
`define ACR_OFS_CTRL 7'h11
`define ACR_OFS_LOAD 7'h13
`define ACR_OFS_PAT_LO 7'h14
`define ACR_OFS_PAT_MID 7'h15
`define ACR_OFS_PAT_HI 7'h16

// ****************************************************************
// Field positions
// ****************************************************************
`define ACR_BIT_SAMPLE_DELAY_LOOP_POWERDOWN 2
`define ACR_BIT_OFFSET_NULL 0
`define ACR_BIT_FUSE_LOAD 0
`define ACR_PAT_HI_MSB 1
`define ACR_SEL_MSB 7
`define ACR_SEL_LSB 5

// ****************************************************************
// Reset values and serial frame geometry
// ****************************************************************
`define ACR_RST_BYTE 8'h00
`define ACR_RST_WORD 18'h0_0000
`define ACR_RST_IFACE 3'h0
`define ACR_FRAME_BITS 5'h10
`define ACR_HDR_BITS 5'h08
`define ACR_CNT_ZERO 5'h00
`define ACR_CNT_ONE 5'h01

`endif

// [hdl/acr_pkg.sv]
// Types shared by the config slice and its serial port
package acr_pkg;

   // Channel B pattern selector codes
   typedef enum logic [2:0]
   {
      ACR_PAT_NORMAL = 3'b000,
      ACR_PAT_RAMP = 3'b010,
      ACR_PAT_CONST = 3'b011
   } acr_pat_t;

   // One register write taken off the serial port
   typedef struct packed
   {
      logic valid;
      logic [6:0] addr;
      logic [7:0] data;
   } acr_wr_t;

endpackage

// [hdl/acr_serial_port.sv]
// Serial control port slave: pin synchronisers, frame shifter, write strobe, read shift-out
`timescale 1ns/1ns
`default_nettype none
`include "acr_regs.svh"

module acr_serial_port
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Serial pins from the host
   input wire logic sclk_i,
   input wire logic sen_n_i,
   input wire logic sdi_i,
   // Read data for the addressed register
   input wire logic [7:0] rdata_i,
   // Register side
   output var acr_pkg::acr_wr_t wr_o,
   output logic [6:0] rd_addr_o,
   // Serial data out pin
   output logic sdo_o,
   output logic sdo_oe_o
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [2:0] meta_reg;   // First stage, read only by the second
   logic [2:0] sync_reg;   // Second stage: {sclk, sen_n, sdi}
   logic [2:0] prev_reg;   // Delayed copy for edge detection

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_reg <= 3'b010;
         sync_reg <= 3'b010;
         prev_reg <= 3'b010;
      end
      else
      begin
         meta_reg <= {sclk_i, sen_n_i, sdi_i};
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic sel;
   assign sclk_rise = sync_reg[2] & ~prev_reg[2];
   assign sclk_fall = ~sync_reg[2] & prev_reg[2];
   assign sel = ~sync_reg[1];

   // ****************************************************************
   // Frame shifter
   // ****************************************************************
   logic [14:0] shift_reg, shift_next;   // Bits taken so far
   logic [4:0] cnt_reg, cnt_next;        // Rising edges in frame
   logic rw_reg, rw_next;                // High for a read frame
   logic [6:0] addr_reg, addr_next;      // Latched register address
   logic [7:0] out_reg, out_next;        // Read shift-out
   acr_pkg::acr_wr_t wr_reg, wr_next;    // Write strobe with data
   logic [15:0] word;                    // Whole frame incl. this bit

   assign word = {shift_reg, sync_reg[0]};

   // Next state of the frame shifter
   always_comb
   begin
      shift_next = shift_reg;
      cnt_next = cnt_reg;
      rw_next = rw_reg;
      addr_next = addr_reg;
      out_next = out_reg;
      wr_next = '0;
      if (!sel)
      begin
         // Deselect aborts any partial frame
         cnt_next = `ACR_CNT_ZERO;
      end
      else if (sclk_rise && cnt_reg != `ACR_FRAME_BITS)
      begin
         shift_next = word[14:0];
         cnt_next = cnt_reg + `ACR_CNT_ONE;
         // Header complete: direction and address
         if (cnt_reg == `ACR_HDR_BITS - `ACR_CNT_ONE)
         begin
            rw_next = word[7];
            addr_next = word[6:0];
         end
         // Last bit of a write frame
         if (cnt_reg == `ACR_FRAME_BITS - `ACR_CNT_ONE && !rw_reg)
         begin
            wr_next.valid = 1'b1;
            wr_next.addr = addr_reg;
            wr_next.data = word[7:0];
         end
      end
      else if (sclk_fall && rw_reg)
      begin
         // First fall after the header loads, later ones shift
         if (cnt_reg == `ACR_HDR_BITS)
            out_next = rdata_i;
         else if (cnt_reg > `ACR_HDR_BITS)
            out_next = {out_reg[6:0], 1'b0};
      end
   end

   // Register the frame shifter
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         shift_reg <= '0;
         cnt_reg <= `ACR_CNT_ZERO;
         rw_reg <= 1'b0;
         addr_reg <= '0;
         out_reg <= `ACR_RST_BYTE;
         wr_reg <= '0;
      end
      else
      begin
         shift_reg <= shift_next;
         cnt_reg <= cnt_next;
         rw_reg <= rw_next;
         addr_reg <= addr_next;
         out_reg <= out_next;
         wr_reg <= wr_next;
      end
   end

   assign wr_o = wr_reg;
   assign rd_addr_o = addr_reg;
   assign sdo_o = out_reg[7];
   // Drive only during the data phase of a read
   assign sdo_oe_o = sel & rw_reg & (cnt_reg >= `ACR_HDR_BITS);

endmodule
`default_nettype wire

// [hdl/acr_config_regs.sv]
// Converter config slice: control byte, output map load, custom pattern and channel B pattern
`timescale 1ns/1ns
`default_nettype none
`include "acr_regs.svh"

// Behaviour
// - Delay-loop power-down selects half-period sampling
// - Bit 0 controls auto-zero, variant-dependent polarity
// - Load bit pulse loads interface bit mapping
// - Fuse load clears other serial register values
// - Custom value: constant pattern and ramp step
// - Selector: 000 normal, 010 ramp, 011 constant
module acr_config_regs
#(
   parameter bit FAST_VARIANT = 1'b1   // Fastest speed grade
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Serial control port pins
   input wire logic sclk_i,
   input wire logic sen_n_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   // Interface choice from the interface-select register
   input wire logic [2:0] iface_sel_i,
   // Converter datapath
   input wire logic sample_en_i,
   input wire logic [17:0] adc_data_i,
   output logic [17:0] chan_b_data_o,
   // Analog controls
   output logic sample_delay_loop_powerdown_o,
   output logic sampling_time_half_o,
   output logic offset_nulling_enable_o,
   // Output bit mapping
   output logic fuse_map_load_o,
   output logic [2:0] active_map_o
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Assemble the 18-bit custom value from its three bytes
   function automatic logic [17:0] fixed_value(input logic [7:0] lo, input logic [7:0] mid,
                                               input logic [7:0] hi);
      fixed_value = {hi[`ACR_PAT_HI_MSB:0], mid, lo};
   endfunction

   // ****************************************************************
   // Serial port
   // ****************************************************************
   acr_pkg::acr_wr_t wr;     // Write strobe from the port
   logic [6:0] rd_addr;      // Address of a read frame
   logic [7:0] rdata;        // Read mux output

   acr_serial_port u_port
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sclk_i(sclk_i),
      .sen_n_i(sen_n_i),
      .sdi_i(sdi_i),
      .rdata_i(rdata),
      .wr_o(wr),
      .rd_addr_o(rd_addr),
      .sdo_o(sdo_o),
      .sdo_oe_o(sdo_oe_o)
   );

   // ****************************************************************
   // Register file
   // ****************************************************************
   logic [7:0] ctrl_reg, ctrl_next;       // Sampling and offset control
   logic [7:0] load_reg, load_next;       // Output map load
   logic [7:0] pat_lo_reg, pat_lo_next;   // Custom value low byte
   logic [7:0] pat_mid_reg, pat_mid_next; // Custom value middle byte
   logic [7:0] pat_hi_reg, pat_hi_next;   // Custom high bits and selector
   logic [2:0] map_reg, map_next;         // Mapping now in effect
   logic load_pulse_reg, load_pulse_next; // Load strobe out
   logic fuse_load;                       // One-then-zero seen

   // A load happens when bit 0 goes from one back to zero
   assign fuse_load = wr.valid && wr.addr == `ACR_OFS_LOAD && load_reg[`ACR_BIT_FUSE_LOAD]
                      && !wr.data[`ACR_BIT_FUSE_LOAD];

   // Next values of the register file
   always_comb
   begin
      ctrl_next = ctrl_reg;
      load_next = load_reg;
      pat_lo_next = pat_lo_reg;
      pat_mid_next = pat_mid_reg;
      pat_hi_next = pat_hi_reg;
      map_next = map_reg;
      load_pulse_next = fuse_load;
      if (fuse_load)
      begin
         // Load wipes earlier configuration writes
         ctrl_next = `ACR_RST_BYTE;
         pat_lo_next = `ACR_RST_BYTE;
         pat_mid_next = `ACR_RST_BYTE;
         pat_hi_next = `ACR_RST_BYTE;
         load_next = wr.data;
         map_next = iface_sel_i;
      end
      else if (wr.valid)
      begin
         // Bits are stored as written; zero-only bits rely on the host
         unique case (wr.addr)
            `ACR_OFS_CTRL: ctrl_next = wr.data;
            `ACR_OFS_LOAD: load_next = wr.data;
            `ACR_OFS_PAT_LO: pat_lo_next = wr.data;
            `ACR_OFS_PAT_MID: pat_mid_next = wr.data;
            `ACR_OFS_PAT_HI: pat_hi_next = wr.data;
            default: ;   // Unmapped: ignored
         endcase
      end
   end

   // Register the register file
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_reg <= `ACR_RST_BYTE;
         load_reg <= `ACR_RST_BYTE;
         pat_lo_reg <= `ACR_RST_BYTE;
         pat_mid_reg <= `ACR_RST_BYTE;
         pat_hi_reg <= `ACR_RST_BYTE;
         map_reg <= `ACR_RST_IFACE;
         load_pulse_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         load_reg <= load_next;
         pat_lo_reg <= pat_lo_next;
         pat_mid_reg <= pat_mid_next;
         pat_hi_reg <= pat_hi_next;
         map_reg <= map_next;
         load_pulse_reg <= load_pulse_next;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      unique case (rd_addr)
         `ACR_OFS_CTRL: rdata = ctrl_reg;
         `ACR_OFS_LOAD: rdata = load_reg;
         `ACR_OFS_PAT_LO: rdata = pat_lo_reg;
         `ACR_OFS_PAT_MID: rdata = pat_mid_reg;
         `ACR_OFS_PAT_HI: rdata = pat_hi_reg;
         default: rdata = `ACR_RST_BYTE;
      endcase
   end

   // ****************************************************************
   // Analog controls
   // ****************************************************************
   // Power-down gives duty-cycle (half period) sampling, else quarter
   assign sample_delay_loop_powerdown_o = ctrl_reg[`ACR_BIT_SAMPLE_DELAY_LOOP_POWERDOWN];
   assign sampling_time_half_o = ctrl_reg[`ACR_BIT_SAMPLE_DELAY_LOOP_POWERDOWN];
   // Polarity flips on the slower grades; the fastest grade passes bit 0 through
   assign offset_nulling_enable_o = FAST_VARIANT ? ctrl_reg[`ACR_BIT_OFFSET_NULL]
                                                 : ~ctrl_reg[`ACR_BIT_OFFSET_NULL];
   assign fuse_map_load_o = load_pulse_reg;
   assign active_map_o = map_reg;

   // ****************************************************************
   // Channel B pattern
   // ****************************************************************
   logic [17:0] custom;                  // Assembled custom value
   logic [17:0] ramp_reg, ramp_next;     // Ramp accumulator
   logic [17:0] chb_reg, chb_next;       // Output sample
   logic [2:0] sel_code;                 // Selector field

   assign custom = fixed_value(pat_lo_reg, pat_mid_reg, pat_hi_reg);
   assign sel_code = pat_hi_reg[`ACR_SEL_MSB:`ACR_SEL_LSB];

   // Next output sample, once per sample strobe
   always_comb
   begin
      ramp_next = ramp_reg;
      chb_next = chb_reg;
      if (sample_en_i)
      begin
         // Ramp restarts from zero on any sample strobe where it is not selected
         ramp_next = `ACR_RST_WORD;
         unique case (sel_code)
            acr_pkg::ACR_PAT_RAMP:
            begin
               chb_next = ramp_reg;
               ramp_next = ramp_reg + custom;
            end
            acr_pkg::ACR_PAT_CONST: chb_next = custom;
            default: chb_next = adc_data_i;
         endcase
      end
   end

   // Register the pattern path
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ramp_reg <= `ACR_RST_WORD;
         chb_reg <= `ACR_RST_WORD;
      end
      else
      begin
         ramp_reg <= ramp_next;
         chb_reg <= chb_next;
      end
   end

   assign chan_b_data_o = chb_reg;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_pdn_follows_write: assert property (wr.valid && wr.addr == `ACR_OFS_CTRL |=>
      sampling_time_half_o == $past(wr.data[`ACR_BIT_SAMPLE_DELAY_LOOP_POWERDOWN]))
      else $error("Sampling time does not follow control write");
   a_nulling_polarity: assert property (wr.valid && wr.addr == `ACR_OFS_CTRL |=>
      offset_nulling_enable_o == (FAST_VARIANT ~^ $past(wr.data[`ACR_BIT_OFFSET_NULL])))
      else $error("Auto-zero polarity wrong");
   a_load_one_zero: assert property ($rose(fuse_map_load_o) |->
      $past(load_reg[`ACR_BIT_FUSE_LOAD], 2) && !load_reg[`ACR_BIT_FUSE_LOAD])
      else $error("Load strobe without one-then-zero");
   a_load_single: assert property (fuse_map_load_o |=> !fuse_map_load_o)
      else $error("Load strobe longer than one cycle");
   a_map_takes_iface: assert property (fuse_load |=> active_map_o == $past(iface_sel_i))
      else $error("Mapping not taken on load");
   a_map_stable: assert property (!fuse_load |=> $stable(active_map_o))
      else $error("Mapping changed without load");
   a_load_clears: assert property (fuse_load |=> ctrl_reg == `ACR_RST_BYTE && custom == `ACR_RST_WORD
      && sel_code == 3'b000)
      else $error("Load did not clear configuration");
   a_const_pattern: assert property (sample_en_i && sel_code == acr_pkg::ACR_PAT_CONST |=>
      chan_b_data_o == $past(custom))
      else $error("Constant pattern mismatch");
   a_ramp_step: assert property (sample_en_i && sel_code == acr_pkg::ACR_PAT_RAMP ##1
      sample_en_i && sel_code == acr_pkg::ACR_PAT_RAMP && $stable(custom) |=>
      chan_b_data_o == 18'($past(chan_b_data_o) + custom))
      else $error("Ramp step mismatch");
   a_normal_pass: assert property (sample_en_i && sel_code != acr_pkg::ACR_PAT_RAMP &&
      sel_code != acr_pkg::ACR_PAT_CONST |=> chan_b_data_o == $past(adc_data_i))
      else $error("Normal path mismatch");

   c_fuse_load: cover property (fuse_map_load_o);
   c_ramp_run: cover property ((sample_en_i && sel_code == acr_pkg::ACR_PAT_RAMP)[*3]);
   c_pdn_set: cover property ($rose(sampling_time_half_o));
   c_read_out: cover property (sdo_oe_o);

endmodule
`default_nettype wire

// [dv/acr_host_model.sv]
// Host controller model that drives the serial control port of the config slice
`timescale 1ns/1ns
`default_nettype none
`include "acr_regs.svh"

module acr_host_model
#(
   parameter int RATE_MSPS = 20,   // Converter sample rate the host runs at
   parameter int HALF_CLK = 6      // Serial clock half period in system clocks
)
(
   // System clock
   input wire logic clk_i,
   // Serial pins toward the device
   output logic sclk_o,
   output logic sen_n_o,
   output logic sdi_o,
   // Serial read data from the device
   input wire logic sdo_i,
   input wire logic sdo_oe_i
);
   // ****************************************************************
   // Idle pin levels
   // ****************************************************************
   // Serial clock stands low outside frames, select stands high
   initial
   begin
      sclk_o = 1'b0;
      sen_n_o = 1'b1;
      sdi_o = 1'b1;
   end

   // Wait a number of system clock edges
   task automatic ticks(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // ****************************************************************
   // One 16-bit frame, MSB first
   // ****************************************************************
   // Slow serial clock: the device synchronises the pins, so each phase spans several clocks
   task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] data, output logic [7:0] rdata);
      logic [15:0] frame;
      logic [7:0] wdata;
      wdata = data;
      // Control byte: reserved bits kept clear
      if (!rd && addr == `ACR_OFS_CTRL)
      begin
         wdata = wdata & 8'h05;
         // Delay loop off only at low sample rates
         if (RATE_MSPS >= 40)
            wdata[`ACR_BIT_SAMPLE_DELAY_LOOP_POWERDOWN] = 1'b0;
      end
      // Load register: only the load bit may be set
      if (!rd && addr == `ACR_OFS_LOAD)
         wdata = wdata & 8'h01;
      frame = {rd, addr, rd ? 8'h00 : wdata};
      rdata = 8'h00;
      @(posedge clk_i);
      sen_n_o <= 1'b0;
      ticks(HALF_CLK);
      for (int i = 15; i >= 0; i--)
      begin
         sdi_o <= frame[i];
         ticks(HALF_CLK);
         sclk_o <= 1'b1;
         // Read data is taken at the rising serial edge
         if (i < 8)
            rdata = {rdata[6:0], sdo_i};
         ticks(HALF_CLK);
         sclk_o <= 1'b0;
      end
      ticks(HALF_CLK);
      sen_n_o <= 1'b1;
      // Released data line shows the inverse so a stale bit is never mistaken for data
      sdi_o <= ~frame[0];
      ticks(8);
   endtask

   // Map load: one then zero on the load bit
   task automatic load_map();
      logic [7:0] unused;
      xfer(1'b0, `ACR_OFS_LOAD, 8'h01, unused);
      xfer(1'b0, `ACR_OFS_LOAD, 8'h00, unused);
   endtask
endmodule
`default_nettype wire

// [dv/adc_misc_config_registers_tb.sv]
// Self-checking testbench for the converter config slice
`timescale 1ns/1ns
`default_nettype none
`include "acr_regs.svh"

`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      end \
   end

module adc_misc_config_registers_tb;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic clk_i = 1'b0;            // 20 MHz system clock
   logic rst_i = 1'b1;            // Reset held at start
   wire sclk;                     // Serial pins from the host model
   wire sen_n;
   wire sdi;
   logic sdo;
   logic sdo_oe;
   logic [2:0] iface_sel = 3'h0;  // Interface choice
   logic sample_en = 1'b0;        // Sample strobe
   logic [17:0] adc_data = 18'h0_0000;
   logic [17:0] chan_b;
   logic pdn;
   logic half;
   logic az;
   logic fload;
   logic [2:0] amap;
   int mismatches = 0;
   int n_tests = 0;
   int n_loads = 0;               // Load pulses seen
   logic [31:0] seed = 32'h0000_11a9;

   always #25 clk_i = ~clk_i;

   // Count load pulses; each is one cycle wide
   always @(posedge clk_i)
      if (fload === 1'b1)
         n_loads++;

   // ****************************************************************
   // Instances
   // ****************************************************************
   acr_config_regs #(.FAST_VARIANT(1'b1)) i_acr_config_regs (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk),
      .sen_n_i(sen_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .iface_sel_i(iface_sel),
      .sample_en_i(sample_en), .adc_data_i(adc_data), .chan_b_data_o(chan_b),
      .sample_delay_loop_powerdown_o(pdn), .sampling_time_half_o(half), .offset_nulling_enable_o(az),
      .fuse_map_load_o(fload), .active_map_o(amap));

   acr_host_model #(.RATE_MSPS(20), .HALF_CLK(6)) i_acr_host_model (.clk_i(clk_i), .sclk_o(sclk),
      .sen_n_o(sen_n), .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(sdo_oe));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Repeatable xorshift source
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Ramp value after k steps, wrapping at 18 bits
   function automatic logic [17:0] ramp_exp(input int k, input logic [17:0] c);
      logic [17:0] acc;
      acc = 18'h0_0000;
      repeat (k) acc = acc + c;
      return acc;
   endfunction

   // Register write through the host
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] unused;
      i_acr_host_model.xfer(1'b0, a, d, unused);
   endtask

   // Register read and compare
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] got;
      i_acr_host_model.xfer(1'b1, a, 8'h00, got);
      `CHK(got, exp)
   endtask

   // One sample strobe, then compare the channel B output
   task automatic samp(input logic [17:0] d, input logic [17:0] exp);
      @(posedge clk_i);
      sample_en <= 1'b1;
      adc_data <= d;
      @(posedge clk_i);
      sample_en <= 1'b0;
      adc_data <= ~d;
      @(posedge clk_i);
      #1;
      `CHK(chan_b, exp)
   endtask

   // Counts, verdict and stop
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Watchdog: far beyond the expected run of about 10000 clocks
   initial
   begin
      #(60000 * 50);
      mismatches++;
      end_sim();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      logic [6:0] regs [5];
      logic [2:0] modes [5];
      logic [7:0] ctl [4];
      logic [2:0] sel;
      logic [17:0] c;
      logic [17:0] d;
      regs = '{`ACR_OFS_CTRL, `ACR_OFS_LOAD, `ACR_OFS_PAT_LO, `ACR_OFS_PAT_MID, `ACR_OFS_PAT_HI};
      modes = '{3'b011, 3'b010, 3'b000, 3'b001, 3'b010};
      ctl = '{8'h04, 8'h01, 8'h05, 8'h00};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      // Reset levels; fast grade reads auto-zero off
      `CHK({pdn, half, az, fload, amap, chan_b}, 25'h000_0000)
      foreach (regs[i])
         rd_chk(regs[i], 8'h00);
      // Unmapped place: write ignored, reads zero
      wr(7'h12, 8'hff);
      rd_chk(7'h12, 8'h00);
      // Interface chosen first, then the load pulse
      sel = 3'(xs());
      @(posedge clk_i);
      iface_sel <= sel;
      i_acr_host_model.load_map();
      `CHK(n_loads, 1)
      `CHK(amap, sel)
      // New choice has no effect until the pulse completes
      @(posedge clk_i);
      iface_sel <= ~sel;
      wr(`ACR_OFS_LOAD, 8'h01);
      `CHK(amap, sel)
      wr(`ACR_OFS_LOAD, 8'h00);
      `CHK(amap, ~sel)
      `CHK(n_loads, 2)
      // Control byte codes
      foreach (ctl[i])
      begin
         wr(`ACR_OFS_CTRL, ctl[i] | 8'hfa);
         `CHK(pdn, ctl[i][2])
         `CHK(half, ctl[i][2])
         `CHK(az, ctl[i][0])
         rd_chk(`ACR_OFS_CTRL, ctl[i]);
      end
      // Pattern modes, ramp re-entered after other modes
      foreach (modes[m])
      begin
         c = 18'(xs());
         wr(`ACR_OFS_PAT_LO, c[7:0]);
         wr(`ACR_OFS_PAT_MID, c[15:8]);
         wr(`ACR_OFS_PAT_HI, {modes[m], 3'b000, c[17:16]});
         rd_chk(`ACR_OFS_PAT_HI, {modes[m], 3'b000, c[17:16]});
         for (int k = 0; k < 4; k++)
         begin
            d = 18'(xs());
            if (modes[m] == 3'b011)
               samp(d, c);
            else if (modes[m] == 3'b010)
               samp(d, ramp_exp(k, c));
            else
               samp(d, d);
         end
      end
      // Back-to-back strobes keep stepping the ramp; last mode above is ramp after four samples
      @(posedge clk_i);
      sample_en <= 1'b1;
      for (int k = 4; k < 7; k++)
      begin
         @(posedge clk_i);
         if (k == 6)
            sample_en <= 1'b0;
         #1;
         `CHK(chan_b, ramp_exp(k, c))
      end
      // A third load wipes earlier settings
      wr(`ACR_OFS_CTRL, 8'h04);
      i_acr_host_model.load_map();
      `CHK(pdn, 1'b0)
      foreach (regs[i])
         rd_chk(regs[i], 8'h00);
      end_sim();
   end
endmodule
`undef CHK
`default_nettype wire
